//--- src/ccb_params.svh
`ifndef CCB_PARAMS_SVH
`define CCB_PARAMS_SVH
// register addresses
`define CCB_ADDR_GAIN_HI 8'h0f
`define CCB_ADDR_GAIN_MID 8'h10
`define CCB_ADDR_GAIN_LO 8'h11
`define CCB_ADDR_MAIN_CHK 8'h12
`define CCB_ADDR_FIR_PORT 8'h13
`define CCB_ADDR_FIR_CHK_HI 8'h14
`define CCB_ADDR_FIR_CHK_LO 8'h15
`define CCB_ADDR_IIR_PORT 8'h16
`define CCB_ADDR_IIR_CHK 8'h17
// reset values
`define CCB_GAIN_RST 24'h400000
`define CCB_MAIN_CHK_RST 8'h00
`define CCB_CRC_INIT 16'h0000
// gain normalisation: 400000h is unity, so shift by 22
`define CCB_GAIN_SHIFT 22
`define CCB_SAT_MAX 24'h7fffff
`define CCB_SAT_MIN 24'h800000
// offset word bytes inside the external register image
`define CCB_OFS_HI 4'hc
`define CCB_OFS_MID 4'hd
`define CCB_OFS_LO 4'he
// scan index space, 9 bits
`define CCB_IDX_ZERO 9'h000
`define CCB_IDX_ONE 9'h001
`define CCB_MAIN_SKIP_FROM 9'h001
`define CCB_MAIN_SKIP_TO 9'h005
`define CCB_MAIN_EXT_LAST 9'h00e
`define CCB_MAIN_LAST 9'h011
`define CCB_FIR_LAST 9'h1ff
`define CCB_IIR_LAST 9'h03f
// memory sizes
`define CCB_FIR_BYTES 512
`define CCB_IIR_BYTES 64
`define CCB_FIR_PTR_ONE 9'h001
`define CCB_IIR_PTR_ONE 6'h01
// check polynomials
`define CCB_MAIN_POLY 8'h07
`define CCB_FIR_POLY 16'h8005
`endif

//--- src/ccb_pkg.sv
package ccb_pkg;
  typedef enum logic [1:0] {ST_IDLE, ST_MAIN, ST_FIR, ST_IIR} ccb_scan_t;
endpackage

//--- src/ccb_crc_byte.sv
`timescale 1ns/1ps
// one byte of a msb-first crc, width and polynomial set by parameters
module ccb_crc_byte #(
  parameter int W = 8,
  parameter logic [W-1:0] POLY = '0
) (
  // running value and byte
  input wire logic [W-1:0] crc_in,
  input wire logic [7:0] data,
  // updated value
  output logic [W-1:0] crc_out
);
  // shift eight data bits through the feedback
  always_comb begin
    logic [W-1:0] c;
    logic fb;
    c = crc_in;
    fb = 1'b0;
    for (int i = 7; i >= 0; i--) begin
      fb = c[W-1] ^ data[i];
      c = {c[W-2:0], 1'b0} ^ (fb ? POLY : '0);
    end
    crc_out = c;
  end
endmodule // ccb_crc_byte

//--- src/ccb_gain_scale.sv
`timescale 1ns/1ps
`include "ccb_params.svh"
// offset subtraction then gain multiply of one conversion result
module ccb_gain_scale
  import ccb_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // calibration words
  input wire logic [23:0] offset_word,
  input wire logic [23:0] gain_word,
  // conversion in
  input wire logic [23:0] conv_data,
  input wire logic conv_valid,
  // corrected result out
  output logic [23:0] result,
  output logic result_valid
);
  logic signed [24:0] diff;
  logic signed [49:0] prod;
  logic signed [49:0] scaled;
  logic [23:0] next_result;

  // offset first, then gain over 400000h
  always_comb begin
    diff = $signed({conv_data[23], conv_data}) - $signed({offset_word[23], offset_word}); // [R3]
    prod = diff * $signed({1'b0, gain_word}); // [R1]
    scaled = prod >>> `CCB_GAIN_SHIFT; // [R2]
    if (scaled > $signed({26'h0, `CCB_SAT_MAX}))
      next_result = `CCB_SAT_MAX;
    else if (scaled < $signed({{26{1'b1}}, `CCB_SAT_MIN}))
      next_result = `CCB_SAT_MIN;
    else
      next_result = scaled[23:0];
  end

  // registered output
  always_ff @(posedge core_clk) begin
    if (reset) begin
      result <= 24'h000000;
      result_valid <= 1'b0;
    end else begin
      result_valid <= conv_valid;
      if (conv_valid)
        result <= next_result;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);

  unity_gain_a: assert property ((conv_valid && gain_word == `CCB_GAIN_RST && offset_word == 24'h000000
      && conv_data != `CCB_SAT_MIN) |=> result == $past(conv_data)) // [R1]
    else $error("unity gain did not pass data unchanged");
  offset_first_a: assert property ((conv_valid && gain_word == `CCB_GAIN_RST && offset_word == conv_data)
      |=> result == 24'h000000) // [R3]
    else $error("offset not subtracted before gain");
endmodule // ccb_gain_scale

//--- src/ccb_bank.sv
`timescale 1ns/1ps
`include "ccb_params.svh"
// What this block does
// R1: gain word is unsigned, 400000h means gain of one.
// R2: result is scaled by gain over 400000h after offset subtraction.
// R3: two's-complement offset is subtracted before the gain.
// R4: main check covers registers 0h, 1h, then 5h through 11h.
// R5: host computes the main check byte and writes it.
// R6: main mismatch sets main error flag and global error flag.
// R7: one enable bit switches on all three checks together.
// R8: finite port reaches 128 coefficients, pointer advances per access.
// R9: access to any other address returns finite pointer to start.
// R10: coefficient memories have no defined value after reset.
// R11: finite check covers all 128 32-bit coefficients, host writes it.
// R12: finite check uses polynomial x^16 + x^15 + x^2 + 1.
// R13: lower finite check address is high byte; mismatch sets flags.
// R14: infinite port advances one byte location per access.
// R15: access to another address restarts infinite pointer at start.
// R16: infinite mismatch sets infinite error flag and global flag.
module ccb_bank
  import ccb_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // device register interface
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  // registers 0h..0eh held elsewhere, byte n at [8n+7:8n]
  input wire logic [119:0] ext_regs,
  // check enable bit of the third config register
  input wire logic crc_enable,
  // error flags and their clears
  input wire logic main_err_clear,
  input wire logic fir_err_clear,
  input wire logic iir_err_clear,
  input wire logic global_err_clear,
  output logic main_err,
  output logic fir_err,
  output logic iir_err,
  output logic global_err,
  // conversion datapath
  input wire logic [23:0] conv_data,
  input wire logic conv_valid,
  output logic [23:0] result,
  output logic result_valid
);
  logic [7:0] gain_hi;
  logic [7:0] gain_mid;
  logic [7:0] gain_lo;
  logic [7:0] main_chk;
  logic [7:0] fir_chk_hi;
  logic [7:0] fir_chk_lo;
  logic [7:0] iir_chk;
  logic [7:0] fir_mem [`CCB_FIR_BYTES];
  logic [7:0] iir_mem [`CCB_IIR_BYTES];
  logic [8:0] fir_ptr;
  logic [5:0] iir_ptr;
  logic access;
  logic wr_main_chk;
  logic wr_fir_chk;
  logic wr_iir_chk;
  logic pend_main;
  logic pend_fir;
  logic pend_iir;
  ccb_scan_t state;
  logic [8:0] idx;
  logic [15:0] crc;
  logic [7:0] scan_byte;
  logic [7:0] next_crc8;
  logic [15:0] next_crc16;
  logic last;
  logic main_bad;
  logic fir_bad;
  logic iir_bad;
  logic [9:0] fir_run;

  assign access = reg_wr | reg_rd;
  assign wr_main_chk = reg_wr && reg_addr == `CCB_ADDR_MAIN_CHK && crc_enable; // [R7]
  assign wr_fir_chk = reg_wr && reg_addr == `CCB_ADDR_FIR_CHK_LO && crc_enable; // [R7]
  assign wr_iir_chk = reg_wr && reg_addr == `CCB_ADDR_IIR_CHK && crc_enable; // [R7]

  // plain byte registers
  always_ff @(posedge core_clk) begin
    if (reset) begin
      gain_hi <= 8'(`CCB_GAIN_RST >> 16);
      gain_mid <= 8'h00;
      gain_lo <= 8'h00;
      main_chk <= `CCB_MAIN_CHK_RST;
      fir_chk_hi <= 8'h00;
      fir_chk_lo <= 8'h00;
      iir_chk <= 8'h00;
    end else if (reg_wr) begin
      unique case (reg_addr)
        `CCB_ADDR_GAIN_HI: gain_hi <= reg_wdata;
        `CCB_ADDR_GAIN_MID: gain_mid <= reg_wdata;
        `CCB_ADDR_GAIN_LO: gain_lo <= reg_wdata;
        `CCB_ADDR_MAIN_CHK: main_chk <= reg_wdata;
        `CCB_ADDR_FIR_CHK_HI: fir_chk_hi <= reg_wdata; // [R13]
        `CCB_ADDR_FIR_CHK_LO: fir_chk_lo <= reg_wdata;
        `CCB_ADDR_IIR_CHK: iir_chk <= reg_wdata;
        default: ;
      endcase
    end
  end

  // coefficient memories, never reset
  always_ff @(posedge core_clk) begin
    if (reg_wr && reg_addr == `CCB_ADDR_FIR_PORT)
      fir_mem[fir_ptr] <= reg_wdata; // [R10]
    if (reg_wr && reg_addr == `CCB_ADDR_IIR_PORT)
      iir_mem[iir_ptr] <= reg_wdata; // [R10]
  end

  // finite pointer: advance on the port, restart elsewhere
  always_ff @(posedge core_clk) begin
    if (reset)
      fir_ptr <= 9'h000;
    else if (access && reg_addr == `CCB_ADDR_FIR_PORT)
      fir_ptr <= fir_ptr + `CCB_FIR_PTR_ONE; // [R8]
    else if (access)
      fir_ptr <= 9'h000; // [R9]
  end

  // infinite pointer: one byte per access, restart elsewhere
  always_ff @(posedge core_clk) begin
    if (reset)
      iir_ptr <= 6'h00;
    else if (access && reg_addr == `CCB_ADDR_IIR_PORT)
      iir_ptr <= iir_ptr + `CCB_IIR_PTR_ONE; // [R14]
    else if (access)
      iir_ptr <= 6'h00; // [R15]
  end

  // registered read data
  always_ff @(posedge core_clk) begin
    if (reset)
      reg_rdata <= 8'h00;
    else if (reg_rd) begin
      unique case (reg_addr)
        `CCB_ADDR_GAIN_HI: reg_rdata <= gain_hi;
        `CCB_ADDR_GAIN_MID: reg_rdata <= gain_mid;
        `CCB_ADDR_GAIN_LO: reg_rdata <= gain_lo;
        `CCB_ADDR_MAIN_CHK: reg_rdata <= main_chk;
        `CCB_ADDR_FIR_PORT: reg_rdata <= fir_mem[fir_ptr];
        `CCB_ADDR_FIR_CHK_HI: reg_rdata <= fir_chk_hi;
        `CCB_ADDR_FIR_CHK_LO: reg_rdata <= fir_chk_lo;
        `CCB_ADDR_IIR_PORT: reg_rdata <= iir_mem[iir_ptr];
        `CCB_ADDR_IIR_CHK: reg_rdata <= iir_chk;
        default: reg_rdata <= 8'h00;
      endcase
    end
  end

  // pending check requests, a new write wins over the start
  always_ff @(posedge core_clk) begin
    if (reset) begin
      pend_main <= 1'b0;
      pend_fir <= 1'b0;
      pend_iir <= 1'b0;
    end else begin
      if (wr_main_chk)
        pend_main <= 1'b1;
      else if (state == ST_IDLE)
        pend_main <= 1'b0;
      if (wr_fir_chk)
        pend_fir <= 1'b1;
      else if (state == ST_IDLE && !pend_main)
        pend_fir <= 1'b0;
      if (wr_iir_chk)
        pend_iir <= 1'b1;
      else if (state == ST_IDLE && !pend_main && !pend_fir)
        pend_iir <= 1'b0;
    end
  end

  // byte fed to the check engines
  always_comb begin
    unique case (state)
      ST_MAIN: begin
        if (idx <= `CCB_MAIN_EXT_LAST)
          scan_byte = ext_regs[{idx[3:0], 3'b000} +: 8];
        else if (idx == `CCB_MAIN_LAST)
          scan_byte = gain_lo;
        else if (idx == `CCB_MAIN_LAST - `CCB_IDX_ONE)
          scan_byte = gain_mid;
        else
          scan_byte = gain_hi;
      end
      ST_FIR: scan_byte = fir_mem[idx];
      ST_IIR: scan_byte = iir_mem[idx[5:0]];
      ST_IDLE: scan_byte = 8'h00;
    endcase
  end

  ccb_crc_byte #(.W(8), .POLY(`CCB_MAIN_POLY)) u_crc8 (
    .crc_in(crc[7:0]),
    .data(scan_byte),
    .crc_out(next_crc8)
  );

  ccb_crc_byte #(.W(16), .POLY(`CCB_FIR_POLY)) u_crc16 ( // [R12]
    .crc_in(crc),
    .data(scan_byte),
    .crc_out(next_crc16)
  );

  // end of scan and comparison outcome
  always_comb begin
    last = (state == ST_MAIN && idx == `CCB_MAIN_LAST)
      || (state == ST_FIR && idx == `CCB_FIR_LAST)
      || (state == ST_IIR && idx == `CCB_IIR_LAST);
    main_bad = state == ST_MAIN && last && next_crc8 != main_chk; // [R6]
    fir_bad = state == ST_FIR && last && next_crc16 != {fir_chk_hi, fir_chk_lo}; // [R13]
    iir_bad = state == ST_IIR && last && next_crc8 != iir_chk; // [R16]
  end

  // scan sequencer, one bank at a time
  always_ff @(posedge core_clk) begin
    if (reset) begin
      state <= ST_IDLE;
      idx <= `CCB_IDX_ZERO;
      crc <= `CCB_CRC_INIT;
    end else begin
      unique case (state)
        ST_IDLE: begin
          idx <= `CCB_IDX_ZERO;
          crc <= `CCB_CRC_INIT;
          if (pend_main)
            state <= ST_MAIN;
          else if (pend_fir)
            state <= ST_FIR; // [R11]
          else if (pend_iir)
            state <= ST_IIR;
        end
        ST_MAIN: begin
          crc <= {8'h00, next_crc8};
          if (idx == `CCB_MAIN_SKIP_FROM)
            idx <= `CCB_MAIN_SKIP_TO; // [R4]
          else
            idx <= idx + `CCB_IDX_ONE;
          if (last)
            state <= ST_IDLE;
        end
        ST_FIR: begin
          crc <= next_crc16;
          idx <= idx + `CCB_IDX_ONE;
          if (last)
            state <= ST_IDLE; // [R11]
        end
        ST_IIR: begin
          crc <= {8'h00, next_crc8};
          idx <= idx + `CCB_IDX_ONE;
          if (last)
            state <= ST_IDLE;
        end
      endcase
    end
  end

  // sticky error flags, set wins over clear
  always_ff @(posedge core_clk) begin
    if (reset) begin
      main_err <= 1'b0;
      fir_err <= 1'b0;
      iir_err <= 1'b0;
      global_err <= 1'b0;
    end else begin
      main_err <= main_bad | (main_err & ~main_err_clear); // [R6]
      fir_err <= fir_bad | (fir_err & ~fir_err_clear); // [R13]
      iir_err <= iir_bad | (iir_err & ~iir_err_clear); // [R16]
      global_err <= main_bad | fir_bad | iir_bad | (global_err & ~global_err_clear);
    end
  end

  ccb_gain_scale u_scale (
    .core_clk(core_clk),
    .reset(reset),
    .offset_word({ext_regs[{`CCB_OFS_HI, 3'b000} +: 8], ext_regs[{`CCB_OFS_MID, 3'b000} +: 8],
      ext_regs[{`CCB_OFS_LO, 3'b000} +: 8]}),
    .gain_word({gain_hi, gain_mid, gain_lo}), // [R2]
    .conv_data(conv_data),
    .conv_valid(conv_valid),
    .result(result),
    .result_valid(result_valid)
  );

  // helper: cycles spent in the finite scan, checked against its length
  always_ff @(posedge core_clk)
    fir_run <= (reset || state != ST_FIR) ? 10'h000 : fir_run + 10'h001;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);

  sequence main_mismatch_s;
    state == ST_MAIN && idx == `CCB_MAIN_LAST && next_crc8 != main_chk;
  endsequence
  sequence fir_mismatch_s;
    state == ST_FIR && idx == `CCB_FIR_LAST && next_crc16 != {fir_chk_hi, fir_chk_lo};
  endsequence

  gain_reset_a: assert property ($fell(reset) |-> {gain_hi, gain_mid, gain_lo} == `CCB_GAIN_RST) // [R1]
    else $error("gain word not unity after reset");
  main_skip_a: assert property (state == ST_MAIN |-> !(idx > `CCB_MAIN_SKIP_FROM
      && idx < `CCB_MAIN_SKIP_TO)) // [R4]
    else $error("main check touched skipped registers");
  main_flag_a: assert property (main_mismatch_s |=> main_err && global_err) // [R6]
    else $error("main mismatch did not raise flags");
  check_off_a: assert property ((!crc_enable && state == ST_IDLE && !pend_main && !pend_fir
      && !pend_iir) |=> state == ST_IDLE) // [R7]
    else $error("check ran while disabled");
  fir_advance_a: assert property ((access && reg_addr == `CCB_ADDR_FIR_PORT)
      |=> fir_ptr == $past(fir_ptr) + `CCB_FIR_PTR_ONE) // [R8]
    else $error("finite pointer did not advance");
  fir_restart_a: assert property ((access && reg_addr != `CCB_ADDR_FIR_PORT) |=> fir_ptr == 9'h000) // [R9]
    else $error("finite pointer not restarted");
  fir_scan_len_a: assert property (state == ST_FIR
      |=> (state == ST_FIR) == (fir_run < `CCB_FIR_BYTES)) // [R11]
    else $error("finite scan length wrong");
  fir_flag_a: assert property (fir_mismatch_s |=> fir_err && global_err) // [R13]
    else $error("finite mismatch did not raise flags");
  iir_advance_a: assert property ((access && reg_addr == `CCB_ADDR_IIR_PORT)
      |=> iir_ptr == $past(iir_ptr) + `CCB_IIR_PTR_ONE) // [R14]
    else $error("infinite pointer did not advance");
  iir_restart_a: assert property ((access && reg_addr != `CCB_ADDR_IIR_PORT) |=> iir_ptr == 6'h00) // [R15]
    else $error("infinite pointer not restarted");
  iir_flag_a: assert property ((state == ST_IIR && idx == `CCB_IIR_LAST && next_crc8 != iir_chk)
      |=> iir_err && global_err) // [R16]
    else $error("infinite mismatch did not raise flags");
endmodule // ccb_bank

//--- tb/ccb_host_model.sv
`timescale 1ns/1ps
// register-bus host: one strobe per byte, driven 1 ns after the edge
module ccb_host_model (
  // clock
  input wire logic core_clk,
  // register bus
  output logic [7:0] reg_addr,
  output logic reg_wr,
  output logic reg_rd,
  output logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata
);
  // idle bus at time zero
  initial begin
    reg_addr = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_wdata = 8'h00;
  end
  // request held over the taking edge, then released lines show the inverse
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    #1;
    reg_addr = a;
    reg_wdata = d;
    reg_wr = w;
    reg_rd = !w;
    @(posedge core_clk);
    #1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask
  // host-computed check bytes go out through here
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    xfer(1'b1, a, d);
  endtask
  // read data is registered, so it is taken one cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    xfer(1'b0, a, 8'h00);
    @(posedge core_clk);
    #1;
    d = reg_rdata;
  endtask
endmodule // ccb_host_model

//--- tb/test_calib_coef_memory_crc_bank.sv
`timescale 1ns/1ps
// self-checking bench for the calibration and check bank
module test_calib_coef_memory_crc_bank;
  import ccb_pkg::*;
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, rb, c8;
  logic reg_wr, reg_rd, crc_enable, conv_valid, result_valid;
  logic main_err_clear, fir_err_clear, iir_err_clear, global_err_clear;
  logic main_err, fir_err, iir_err, global_err;
  logic [119:0] ext_regs;
  logic [23:0] conv_data, result, gain;
  logic [15:0] c16;
  logic [7:0] img [0:17];
  logic [7:0] mem [0:511];
  longint d, q;
  int n_fail = 0;
  int n_compared = 0;

  // 100 ns clock
  always #50 core_clk = ~core_clk;

  ccb_bank i_ccb_bank (.core_clk(core_clk), .reset(reset), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .ext_regs(ext_regs), .crc_enable(crc_enable), .main_err_clear(main_err_clear),
    .fir_err_clear(fir_err_clear), .iir_err_clear(iir_err_clear),
    .global_err_clear(global_err_clear), .main_err(main_err), .fir_err(fir_err),
    .iir_err(iir_err), .global_err(global_err), .conv_data(conv_data),
    .conv_valid(conv_valid), .result(result), .result_valid(result_valid));

  ccb_host_model i_ccb_host_model (.core_clk(core_clk), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));

  // compare and count
  task automatic chk(input logic [47:0] seen, input logic [47:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // closing report
  task automatic print_verdict();
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // reference crc steps, msb first
  function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] b);
    c = c ^ b;
    for (int i = 0; i < 8; i++) c = c[7] ? ((c << 1) ^ 8'h07) : (c << 1);
    return c;
  endfunction
  function automatic logic [15:0] crc16(input logic [15:0] c, input logic [7:0] b);
    c = c ^ {b, 8'h00};
    for (int i = 0; i < 16 - 8; i++) c = c[15] ? ((c << 1) ^ 16'h8005) : (c << 1);
    return c;
  endfunction

  // write a check byte, wait for the flags, compare, then clear them
  task automatic check_byte(input logic [7:0] a, input logic [7:0] v,
                            input logic [3:0] exp, input int lim);
    int t;
    i_ccb_host_model.wr(a, v);
    for (t = 0; t < lim; t++) begin
      if (exp != 4'h0 && global_err === 1'b1) break;
      @(posedge core_clk);
      #1;
    end
    if (exp != 4'h0 && t == lim) begin
      chk(1'b0, 1'b1);
      print_verdict();
    end
    repeat (2) @(posedge core_clk);
    #1;
    chk({main_err, fir_err, iir_err, global_err}, exp);
    {main_err_clear, fir_err_clear, iir_err_clear, global_err_clear} = 4'hf;
    @(posedge core_clk);
    #1;
    {main_err_clear, fir_err_clear, iir_err_clear, global_err_clear} = 4'h0;
    chk({main_err, fir_err, iir_err, global_err}, 4'h0);
  endtask

  // fill a coefficient port, with pointer restarts before fill and readback
  task automatic mem_pass(input logic [7:0] a, input int n);
    repeat (n / 4 + 3) i_ccb_host_model.wr(a, 8'($urandom));
    i_ccb_host_model.rd(8'h30, rb);
    for (int i = 0; i < n; i++) begin
      mem[i] = 8'($urandom);
      i_ccb_host_model.wr(a, mem[i]);
    end
    i_ccb_host_model.rd(8'h30, rb);
    repeat (10) i_ccb_host_model.rd(a, rb);
    i_ccb_host_model.rd(8'h30, rb);
    for (int i = 0; i < n; i++) begin
      i_ccb_host_model.rd(a, rb);
      chk(rb, mem[i]);
    end
  endtask

  // main sequence
  initial begin
    void'($urandom(84733));
    crc_enable = 1'b0;
    conv_valid = 1'b0;
    conv_data = 24'h000000;
    {main_err_clear, fir_err_clear, iir_err_clear, global_err_clear} = 4'h0;
    for (int i = 0; i < 15; i++) begin
      img[i] = 8'($urandom);
      ext_regs[8 * i +: 8] = img[i];
    end
    repeat (4) @(posedge core_clk);
    #1;
    reset = 1'b0;
    // reset values and an unmapped read
    for (int a = 15; a < 19; a++) begin
      i_ccb_host_model.rd(8'(a), rb);
      chk(rb, (a == 15) ? 8'h40 : 8'h00);
    end
    i_ccb_host_model.rd(8'h30, rb);
    chk(rb, 8'h00);
    // offset then gain on conversion results, unity gain with data equal to offset first, then unity gain and zero offset
    for (int k = 0; k < 6; k++) begin
      gain = (k < 2) ? 24'h400000 : 24'($urandom_range(24'h7fffff));
      if (k == 1) begin
        for (int j = 12; j < 15; j++) img[j] = 8'h00;
        ext_regs[96 +: 24] = 24'h000000;
      end
      for (int j = 0; j < 3; j++) begin
        img[15 + j] = gain[23 - 8 * j -: 8];
        i_ccb_host_model.wr(8'(15 + j), img[15 + j]);
      end
      @(posedge core_clk);
      #1;
      conv_data = (k == 0) ? {img[12], img[13], img[14]} : 24'($urandom);
      conv_valid = 1'b1;
      @(posedge core_clk);
      #1;
      conv_valid = 1'b0;
      d = longint'(signed'(conv_data)) - longint'(signed'({img[12], img[13], img[14]}));
      q = (d * longint'(gain)) >>> 22;
      if (q > 64'sd8388607) q = 64'sd8388607;
      if (q < -64'sd8388608) q = -64'sd8388608;
      chk({result_valid, result}, {1'b1, q[23:0]});
    end
    // main check over 0h..1h and 5h..11h
    c8 = 8'h00;
    for (int i = 0; i < 18; i++) if (i < 2 || i > 4) c8 = crc8(c8, img[i]);
    crc_enable = 1'b1;
    check_byte(8'h12, c8, 4'b0000, 40);
    check_byte(8'h12, c8 ^ 8'h5a, 4'b1001, 40);
    crc_enable = 1'b0;
    check_byte(8'h12, c8 ^ 8'h5a, 4'b0000, 40);
    crc_enable = 1'b1;
    // finite bank: 128 coefficients of 32 bits
    mem_pass(8'h13, 512);
    c16 = 16'h0000;
    for (int i = 0; i < 512; i++) c16 = crc16(c16, mem[i]);
    i_ccb_host_model.wr(8'h14, c16[15:8]);
    check_byte(8'h15, c16[7:0], 4'b0000, 600);
    i_ccb_host_model.wr(8'h14, ~c16[15:8]);
    check_byte(8'h15, c16[7:0], 4'b0101, 600);
    // infinite bank
    mem_pass(8'h16, 64);
    c8 = 8'h00;
    for (int i = 0; i < 64; i++) c8 = crc8(c8, mem[i]);
    check_byte(8'h17, c8, 4'b0000, 100);
    check_byte(8'h17, ~c8, 4'b0011, 100);
    print_verdict();
  end
endmodule // test_calib_coef_memory_crc_bank
